/* File: fchd_top.v */
// Summary of operation
// (RULE_01) Full-closed logic works only in full-closed mode, with servo on, on a non-standard drive.
// (RULE_02) A control structure setting turns two-degree-of-freedom control off, or on as standard or sync.
// (RULE_03) With that control off, the command goes through a first-order lag of 0 to 10000 x 0.1 ms.
// (RULE_04) Bit 14 picks filtered (0) or unfiltered (1) command minus actual for the position deviation.
// (RULE_05) Bit 3 picks the accumulated command count before (0) or after (1) the smoothing filter.
// (RULE_06) Reported motor velocity in r/min comes only from encoder feedback.
// (RULE_07) The scale numerator spans 0 to 2^27 and 0 means the encoder resolution is used.
// (RULE_08) The scale denominator spans 1 to 2^27 and scale pulses are scaled by numerator/denominator.
// (RULE_09) Software sets the ratio to encoder pulses per turn over scale pulses per turn.
// (RULE_10) Encoder minus converted scale position is tracked and flags an error past a 1..2^27 threshold.
// (RULE_11) The hybrid deviation is zeroed every 1..100 motor turns, and never when the setting is 0.
// (RULE_12) Turns for periodic clearing are counted from encoder pulses only.
// (RULE_13) An absolute system zeroes the hybrid deviation at power-up position initialisation.
// (RULE_14) Completion of homing zeroes the hybrid deviation.
// (RULE_15) Completion of a reset command in the attribute C mode zeroes the hybrid deviation.
// (RULE_16) Completion of any service tool operation zeroes the hybrid deviation.
// (RULE_17) The excess check uses the magnitude, so either sign past the threshold trips it.
`include "fchd_defs.vh"

module fchd_top (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // drive state
    input wire full_closed_mode,
    input wire servo_on,
    input wire drive_is_standard,
    input wire absolute_system,
    input wire attr_c_mode,
    // position initialisation events, one-cycle pulses
    input wire power_up_init_done,
    input wire homing_done,
    input wire reset_cmd_done,
    input wire [5:0] tool_op_done,
    // position streams, signed pulse deltas per cycle
    input wire signed [15:0] cmd_delta,
    input wire signed [15:0] enc_delta,
    input wire signed [15:0] scale_delta,
    // results
    output reg hybrid_excess_alarm,
    output reg irq
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [1:0] control_structure_select;
    reg [13:0] command_smoothing_time_constant;
    reg [15:0] link_extension_setup_two;
    reg [15:0] link_extension_setup_six;
    reg [27:0] scale_ratio_numerator;
    reg [27:0] scale_ratio_denominator;
    reg [27:0] hybrid_excess_threshold;
    reg [6:0] hybrid_clear_interval;
    reg [`FCHD_ST_W-1:0] status;
    reg [`FCHD_ST_W-1:0] mask;

    wire wr_en = psel & penable & pready & pwrite;
    wire [31:0] wd = pwdata;

    // ----------------------------------------
    // position state
    // ----------------------------------------
    reg signed [31:0] cmd_pos;
    reg signed [31:0] enc_pos;
    reg signed [31:0] scale_cnt;
    reg signed [31:0] load_pos;
    reg signed [31:0] enc_base;
    reg signed [31:0] load_base;
    reg signed [31:0] hyb_dev;
    reg signed [31:0] pos_dev;
    reg signed [31:0] cmd_acc;
    reg signed [31:0] velocity;
    reg signed [31:0] vel_acc;
    reg [9:0] tick_cnt;
    reg [3:0] vel_ticks;
    reg [27:0] rot_pulses;
    reg [6:0] rot_cnt;
    wire signed [31:0] filt_pos;

    // ----------------------------------------
    // operating conditions
    // ----------------------------------------
    wire active = full_closed_mode & servo_on & ~drive_is_standard; // [RULE_01]
    wire two_dof_on = (control_structure_select != `FCHD_SEL_OFF); // [RULE_02]

    wire tick = (tick_cnt == `FCHD_TICK_CYCLES - 1);

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt <= 10'h000;
        end else if (tick) begin
            tick_cnt <= 10'h000;
        end else begin
            tick_cnt <= tick_cnt + 10'h001;
        end
    end

    // ----------------------------------------
    // command smoothing
    // ----------------------------------------
    // with two-degree-of-freedom control on, its own shaping applies, so the lag is bypassed
    fchd_lag u_lag (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .tick(tick),
        .bypass(two_dof_on),
        .time_const(command_smoothing_time_constant),
        .x_in(cmd_pos),
        .y_out(filt_pos)
    ); // [RULE_03]

    // ----------------------------------------
    // scale to encoder conversion
    // ----------------------------------------
    wire [27:0] num_eff = (scale_ratio_numerator == 28'h0000000) ?
                          `FCHD_ENC_RES : scale_ratio_numerator; // [RULE_07]
    wire [27:0] den_eff = (scale_ratio_denominator == 28'h0000000) ?
                          28'h0000001 : scale_ratio_denominator;
    wire signed [15:0] enc_d = enc_delta;
    wire signed [31:0] enc_pos_next = enc_pos + {{16{enc_d[15]}}, enc_d};
    wire signed [31:0] scale_next = scale_cnt + {{16{scale_delta[15]}}, scale_delta};
    wire signed [63:0] scale_prod = scale_next * $signed({36'h000000000, num_eff});
    wire signed [63:0] scale_conv = scale_prod / $signed({36'h000000000, den_eff}); // [RULE_08]

    // ----------------------------------------
    // clear events
    // ----------------------------------------
    wire init_clear = (absolute_system & power_up_init_done) // [RULE_13]
                    | homing_done // [RULE_14]
                    | (reset_cmd_done & attr_c_mode) // [RULE_15]
                    | (|tool_op_done); // [RULE_16]

    // turns counted on encoder pulses so a slipping scale cannot stretch the interval
    wire [15:0] enc_mag = enc_d[15] ? (16'h0000 - enc_d) : enc_d;
    wire [28:0] rot_sum = {1'b0, rot_pulses} + {13'h0000, enc_mag}; // [RULE_12]
    wire turn_done = (rot_sum >= {1'b0, `FCHD_ENC_RES});
    wire periodic_clear = active && turn_done && (hybrid_clear_interval != 7'h00) &&
                          (rot_cnt + 7'h01 >= hybrid_clear_interval); // [RULE_11]
    wire hyb_clear = init_clear | periodic_clear | ~active;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rot_pulses <= 28'h0000000;
            rot_cnt <= 7'h00;
        end else if (~active || hybrid_clear_interval == 7'h00 || init_clear) begin
            rot_pulses <= 28'h0000000;
            rot_cnt <= 7'h00;
        end else if (turn_done) begin
            rot_pulses <= rot_sum[27:0] - `FCHD_ENC_RES;
            rot_cnt <= periodic_clear ? 7'h00 : rot_cnt + 7'h01;
        end else begin
            rot_pulses <= rot_sum[27:0];
        end
    end

    // ----------------------------------------
    // positions and hybrid deviation
    // ----------------------------------------
    wire signed [31:0] load_next = scale_conv[31:0];
    wire signed [31:0] hyb_next = (enc_pos_next - enc_base) - (load_next - load_base); // [RULE_10]
    wire [31:0] hyb_mag = hyb_dev[31] ? (32'h00000000 - hyb_dev) : hyb_dev; // [RULE_17]
    wire [27:0] thr_eff = (hybrid_excess_threshold == 28'h0000000) ?
                          28'h0000001 : hybrid_excess_threshold;
    wire excess_evt = active && (hyb_mag > {4'h0, thr_eff}); // [RULE_10]

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_pos <= 32'sh0;
            enc_pos <= 32'sh0;
            scale_cnt <= 32'sh0;
            load_pos <= 32'sh0;
            enc_base <= 32'sh0;
            load_base <= 32'sh0;
            hyb_dev <= 32'sh0;
        end else begin
            cmd_pos <= cmd_pos + {{16{cmd_delta[15]}}, cmd_delta};
            enc_pos <= enc_pos_next;
            scale_cnt <= scale_next;
            load_pos <= load_next;
            if (hyb_clear) begin
                enc_base <= enc_pos_next;
                load_base <= load_next;
                hyb_dev <= 32'sh0;
            end else begin
                hyb_dev <= hyb_next;
            end
        end
    end

    // ----------------------------------------
    // monitors
    // ----------------------------------------
    // actual position in full-closed control is the load side, in encoder units
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_dev <= 32'sh0;
            cmd_acc <= 32'sh0;
        end else begin
            pos_dev <= (link_extension_setup_two[`FCHD_DEV_SRC_BIT] ? cmd_pos : filt_pos)
                       - load_pos; // [RULE_04]
            cmd_acc <= link_extension_setup_six[`FCHD_ACC_SRC_BIT] ? filt_pos : cmd_pos; // [RULE_05]
        end
    end

    wire signed [63:0] vel_prod = vel_acc * 64'sd60000;
    wire signed [63:0] vel_rpm = vel_prod / $signed({36'h000000000, `FCHD_ENC_RES});

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vel_acc <= 32'sh0;
            vel_ticks <= 4'h0;
            velocity <= 32'sh0;
        end else if (tick && vel_ticks == `FCHD_VEL_TICKS - 1) begin
            vel_ticks <= 4'h0;
            vel_acc <= {{16{enc_d[15]}}, enc_d};
            velocity <= vel_rpm[31:0]; // [RULE_06]
        end else begin
            if (tick) begin
                vel_ticks <= vel_ticks + 4'h1;
            end
            vel_acc <= vel_acc + {{16{enc_d[15]}}, enc_d}; // [RULE_06]
        end
    end

    // ----------------------------------------
    // status, interrupt and alarm
    // ----------------------------------------
    wire [`FCHD_ST_W-1:0] st_set = {init_clear, periodic_clear, excess_evt};
    wire [`FCHD_ST_W-1:0] st_clr = (wr_en && paddr == `FCHD_ADDR_STATUS) ?
                                   wd[`FCHD_ST_W-1:0] : {`FCHD_ST_W{1'b0}};
    wire [`FCHD_ST_W-1:0] st_next = (status & ~st_clr) | st_set;

    // a set in the same cycle as its clear wins, so no event is lost
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status <= {`FCHD_ST_W{1'b0}};
            irq <= 1'b0;
            hybrid_excess_alarm <= 1'b0;
        end else begin
            status <= st_next;
            irq <= |(st_next & mask);
            hybrid_excess_alarm <= st_next[`FCHD_ST_EXCESS]; // [RULE_10]
        end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // out-of-range values are clamped so the datapath never sees an illegal setting
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            control_structure_select <= `FCHD_SEL_OFF;
            command_smoothing_time_constant <= `FCHD_RST_SMOOTH_TC;
            link_extension_setup_two <= 16'h0000;
            link_extension_setup_six <= 16'h0000;
            scale_ratio_numerator <= `FCHD_RST_RATIO_NUM;
            scale_ratio_denominator <= `FCHD_RST_RATIO_DEN;
            hybrid_excess_threshold <= `FCHD_RST_EXCESS_THR;
            hybrid_clear_interval <= `FCHD_RST_CLEAR_INT;
            mask <= {`FCHD_ST_W{1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `FCHD_ADDR_CTRL_SEL: begin
                    control_structure_select <= (wd[1:0] == 2'h3) ? `FCHD_SEL_SYNC : wd[1:0];
                end
                `FCHD_ADDR_SMOOTH_TC: begin
                    command_smoothing_time_constant <= (wd[31:0] > {18'h0, `FCHD_MAX_TC}) ?
                                                       `FCHD_MAX_TC : wd[13:0];
                end
                `FCHD_ADDR_LINK_TWO: begin
                    link_extension_setup_two <= wd[15:0];
                end
                `FCHD_ADDR_LINK_SIX: begin
                    link_extension_setup_six <= wd[15:0];
                end
                `FCHD_ADDR_RATIO_NUM: begin
                    scale_ratio_numerator <= (wd > {4'h0, `FCHD_MAX_RATIO}) ?
                                             `FCHD_MAX_RATIO : wd[27:0];
                end
                `FCHD_ADDR_RATIO_DEN: begin
                    scale_ratio_denominator <= (wd > {4'h0, `FCHD_MAX_RATIO}) ? `FCHD_MAX_RATIO :
                                               (wd == 32'h0) ? 28'h0000001 : wd[27:0];
                end
                `FCHD_ADDR_EXCESS_THR: begin
                    hybrid_excess_threshold <= (wd > {4'h0, `FCHD_MAX_RATIO}) ? `FCHD_MAX_RATIO :
                                               (wd == 32'h0) ? 28'h0000001 : wd[27:0];
                end
                `FCHD_ADDR_CLEAR_INT: begin
                    hybrid_clear_interval <= (wd > {25'h0, `FCHD_MAX_CLEAR_INT}) ?
                                             `FCHD_MAX_CLEAR_INT : wd[6:0];
                end
                `FCHD_ADDR_MASK: begin
                    mask <= wd[`FCHD_ST_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    // data is caught in the setup cycle; every access completes with one wait-free access phase
    reg [31:0] next_prdata;
    reg next_err;

    always @* begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            `FCHD_ADDR_CTRL_SEL: next_prdata = {30'h0, control_structure_select};
            `FCHD_ADDR_SMOOTH_TC: next_prdata = {18'h0, command_smoothing_time_constant};
            `FCHD_ADDR_LINK_TWO: next_prdata = {16'h0, link_extension_setup_two};
            `FCHD_ADDR_LINK_SIX: next_prdata = {16'h0, link_extension_setup_six};
            `FCHD_ADDR_RATIO_NUM: next_prdata = {4'h0, scale_ratio_numerator};
            `FCHD_ADDR_RATIO_DEN: next_prdata = {4'h0, scale_ratio_denominator};
            `FCHD_ADDR_EXCESS_THR: next_prdata = {4'h0, hybrid_excess_threshold};
            `FCHD_ADDR_CLEAR_INT: next_prdata = {25'h0, hybrid_clear_interval};
            `FCHD_ADDR_STATUS: next_prdata = {29'h0, status};
            `FCHD_ADDR_MASK: next_prdata = {29'h0, mask};
            `FCHD_ADDR_HYB_DEV: next_prdata = hyb_dev;
            `FCHD_ADDR_POS_DEV: next_prdata = pos_dev;
            `FCHD_ADDR_CMD_ACC: next_prdata = cmd_acc;
            `FCHD_ADDR_VELOCITY: next_prdata = velocity;
            default: next_err = 1'b1;
        endcase
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= next_err;
            prdata <= pwrite ? 32'h00000000 : next_prdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

/* File: fchd_defs.vh */
`ifndef FCHD_DEFS_VH
`define FCHD_DEFS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define FCHD_ADDR_CTRL_SEL    12'h000
`define FCHD_ADDR_SMOOTH_TC   12'h004
`define FCHD_ADDR_LINK_TWO    12'h008
`define FCHD_ADDR_LINK_SIX    12'h00c
`define FCHD_ADDR_RATIO_NUM   12'h010
`define FCHD_ADDR_RATIO_DEN   12'h014
`define FCHD_ADDR_EXCESS_THR  12'h018
`define FCHD_ADDR_CLEAR_INT   12'h01c
`define FCHD_ADDR_STATUS      12'h020
`define FCHD_ADDR_MASK        12'h024
`define FCHD_ADDR_HYB_DEV     12'h028
`define FCHD_ADDR_POS_DEV     12'h02c
`define FCHD_ADDR_CMD_ACC     12'h030
`define FCHD_ADDR_VELOCITY    12'h034

// ----------------------------------------
// fields
// ----------------------------------------
`define FCHD_SEL_OFF          2'h0
`define FCHD_SEL_STANDARD     2'h1
`define FCHD_SEL_SYNC         2'h2
`define FCHD_DEV_SRC_BIT      14
`define FCHD_ACC_SRC_BIT      3
`define FCHD_ST_EXCESS        0
`define FCHD_ST_PERIODIC      1
`define FCHD_ST_INIT          2
`define FCHD_ST_W             3

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define FCHD_RST_SMOOTH_TC    14'h0000
`define FCHD_RST_RATIO_NUM    28'h0000000
`define FCHD_RST_RATIO_DEN    28'h0000001
`define FCHD_RST_EXCESS_THR   28'h0004000
`define FCHD_RST_CLEAR_INT    7'h00
`define FCHD_MAX_TC           14'h2710
`define FCHD_MAX_RATIO        28'h8000000
`define FCHD_MAX_CLEAR_INT    7'h64
`define FCHD_ENC_RES          28'h8000000

// ----------------------------------------
// timing
// ----------------------------------------
`define FCHD_CLK_MHZ          10
`define FCHD_TICK_US          100
`define FCHD_TICK_CYCLES      (`FCHD_TICK_US * `FCHD_CLK_MHZ)
`define FCHD_VEL_TICKS        10
`define FCHD_MIN_PER_MS       60000

`endif

/* File: fchd_lag.v */
`include "fchd_defs.vh"

module fchd_lag (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // control
    input wire tick,
    input wire bypass,
    input wire [13:0] time_const,
    // data
    input wire signed [31:0] x_in,
    output reg signed [31:0] y_out
);

    wire signed [31:0] err = x_in - y_out;
    wire signed [31:0] tc_s = {18'h00000, time_const};
    wire signed [31:0] quot = (time_const == 14'h0000) ? err : err / tc_s;
    reg signed [31:0] step;

    // a pure quotient stalls short of the input; a unit nudge lets it settle exactly
    always @* begin
        step = quot;
        if (quot == 32'sh0 && err != 32'sh0) begin
            step = err[31] ? -32'sh1 : 32'sh1;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            y_out <= 32'sh0;
        end else if (bypass || time_const == 14'h0000) begin
            y_out <= x_in;
        end else if (tick) begin
            y_out <= y_out + step;
        end
    end

endmodule

/* File: fchd_props.sv */
`include "fchd_defs.vh"

module fchd_props (
    // clock and reset
    input core_clk,
    input sys_rst,
    // apb
    input psel,
    input penable,
    input pwrite,
    input [11:0] paddr,
    input [31:0] pwdata,
    input [31:0] prdata,
    input pready,
    input pslverr,
    // drive state and position events
    input full_closed_mode,
    input servo_on,
    input drive_is_standard,
    input absolute_system,
    input attr_c_mode,
    input power_up_init_done,
    input homing_done,
    input reset_cmd_done,
    input [5:0] tool_op_done,
    input hybrid_excess_alarm
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire active = full_closed_mode && servo_on && !drive_is_standard;
    wire st_clear = psel && penable && pready && pwrite && paddr == `FCHD_ADDR_STATUS && pwdata[0];
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_access;
        psel && penable && pready;
    endsequence
    // skip the edge whose compare still saw the old deviation
    sequence no_new_alarm;
        ##1 !$rose(hybrid_excess_alarm);
    endsequence
    AST_APB_ANSWER: assert property (apb_setup |=> apb_access)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_WRITE_NO_DATA: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on a write");
    AST_ALARM_ACTIVE: assert property ($rose(hybrid_excess_alarm) |-> $past(active))
        else $error("alarm raised while inactive");
    AST_ALARM_STICKY: assert property (hybrid_excess_alarm && !st_clear |=> hybrid_excess_alarm)
        else $error("alarm dropped without clear");
    AST_PWRUP_CLEAR: assert property (power_up_init_done && absolute_system |=> no_new_alarm)
        else $error("alarm after power-up init");
    AST_HOME_CLEAR: assert property (homing_done |=> no_new_alarm)
        else $error("alarm after homing");
    AST_RSTCMD_CLEAR: assert property (reset_cmd_done && attr_c_mode |=> no_new_alarm)
        else $error("alarm after reset command");
    AST_TOOL_CLEAR: assert property (tool_op_done != 6'h00 |=> no_new_alarm)
        else $error("alarm after tool operation");
endmodule

bind fchd_top fchd_props props (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .full_closed_mode(full_closed_mode), .servo_on(servo_on),
    .drive_is_standard(drive_is_standard), .absolute_system(absolute_system),
    .attr_c_mode(attr_c_mode), .power_up_init_done(power_up_init_done),
    .homing_done(homing_done), .reset_cmd_done(reset_cmd_done), .tool_op_done(tool_op_done),
    .hybrid_excess_alarm(hybrid_excess_alarm)
);

/* File: fchd_feedback_model.sv */
module fchd_feedback_model (
    // clock and reset
    input core_clk,
    input sys_rst,
    // motion request
    input run,
    input signed [15:0] enc_rate,
    input signed [15:0] scale_rate,
    // pulse streams
    output logic signed [15:0] enc_delta,
    output logic signed [15:0] scale_delta
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // encoder and scale streams
    // ----------------------------------------
    // idle streams carry zero; the block sums every edge
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst || !run) begin
            enc_delta <= 16'sh0;
            scale_delta <= 16'sh0;
        end else begin
            enc_delta <= enc_rate;
            scale_delta <= scale_rate;
        end
    end
endmodule

/* File: test_full_closed_hybrid_deviation.sv */
`include "fchd_defs.vh"

module test_full_closed_hybrid_deviation;
    timeunit 1ns;
    timeprecision 1ns;
    localparam hyb_a = `FCHD_ADDR_HYB_DEV;
    localparam st_a = `FCHD_ADDR_STATUS;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, hybrid_excess_alarm, irq, er, run = 1'b0;
    logic full_closed_mode = 1'b0, servo_on = 1'b0, drive_is_standard = 1'b0;
    logic absolute_system = 1'b1, attr_c_mode = 1'b0;
    logic [8:0] ev = 9'h000;
    logic signed [15:0] cmd_delta = 16'sh0003, enc_delta, scale_delta;
    logic signed [15:0] enc_rate = 16'sh0, scale_rate = 16'sh0;
    int fail_count = 0, n_compared = 0, i;
    logic [11:0] cl_a [10] = '{12'h000, 12'h000, 12'h004, 12'h010, 12'h014, 12'h018, 12'h018,
        12'h01c, 12'h008, 12'h00c};
    logic [31:0] cl_w [10] = '{32'h3, 32'h1, 32'h4e20, 32'h9000000, 32'h0, 32'h0, 32'h9000000,
        32'hc8, 32'h4000, 32'h8};
    logic [31:0] cl_r [10] = '{32'h2, 32'h1, 32'h2710, 32'h8000000, 32'h1, 32'h1, 32'h8000000,
        32'h64, 32'h4000, 32'h8};

    always #50 core_clk = ~core_clk;

    fchd_top uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .full_closed_mode(full_closed_mode), .servo_on(servo_on),
        .drive_is_standard(drive_is_standard), .absolute_system(absolute_system),
        .attr_c_mode(attr_c_mode), .power_up_init_done(ev[0]), .homing_done(ev[1]),
        .reset_cmd_done(ev[2]), .tool_op_done(ev[8:3]), .cmd_delta(cmd_delta),
        .enc_delta(enc_delta), .scale_delta(scale_delta),
        .hybrid_excess_alarm(hybrid_excess_alarm), .irq(irq)
    );
    fchd_feedback_model feedback (
        .core_clk(core_clk), .sys_rst(sys_rst), .run(run), .enc_rate(enc_rate),
        .scale_rate(scale_rate), .enc_delta(enc_delta), .scale_delta(scale_delta)
    );

    // ----------------------------------------
    // access and check tasks
    // ----------------------------------------
    task stop_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask

    // n edges of motion reach the block
    task move(input logic signed [15:0] e, s, input int n);
        @(posedge core_clk);
        run <= 1'b1;
        enc_rate <= e;
        scale_rate <= s;
        repeat (n) @(posedge core_clk);
        run <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task pulse(input int k);
        @(posedge core_clk);
        ev <= 9'h001 << k;
        @(posedge core_clk);
        ev <= 9'h000;
        repeat (2) @(posedge core_clk);
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdchk(`FCHD_ADDR_EXCESS_THR, 32'h4000);
        rdchk(`FCHD_ADDR_RATIO_DEN, 32'h1);
        rdchk(`FCHD_ADDR_RATIO_NUM, 32'h0);
        rdchk(`FCHD_ADDR_CLEAR_INT, 32'h0);
        rdchk(12'h040, 32'h0);
        chk(er, 1'b1);
        for (i = 0; i < 10; i++) begin
            apb(cl_a[i], 1'b1, cl_w[i]);
            rdchk(cl_a[i], cl_r[i]);
        end
        apb(`FCHD_ADDR_RATIO_NUM, 1'b1, 32'h1);
        apb(`FCHD_ADDR_EXCESS_THR, 1'b1, 32'h64);
        apb(`FCHD_ADDR_CLEAR_INT, 1'b1, 32'h0);
        apb(`FCHD_ADDR_MASK, 1'b1, 32'h7);
        full_closed_mode <= 1'b1;
        servo_on <= 1'b1;
        move(16'sh32, 16'sh0, 2);
        rdchk(hyb_a, 32'h64);
        chk(hybrid_excess_alarm, 1'b0);
        move(16'sh1, 16'sh0, 1);
        rdchk(hyb_a, 32'h65);
        chk({hybrid_excess_alarm, irq}, 2'h3);
        pulse(1);
        rdchk(hyb_a, 32'h0);
        rdchk(st_a, 32'h5);
        apb(st_a, 1'b1, 32'h7);
        repeat (2) @(posedge core_clk);
        chk({hybrid_excess_alarm, irq}, 2'h0);
        move(16'sh0, 16'sh65, 1);
        rdchk(hyb_a, 32'hffffff9b);
        chk(hybrid_excess_alarm, 1'b1);
        apb(`FCHD_ADDR_MASK, 1'b1, 32'h0);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b0);
        pulse(1);
        apb(st_a, 1'b1, 32'h7);
        move(16'sh14, 16'sh0, 1);
        pulse(2);
        rdchk(hyb_a, 32'h14);
        attr_c_mode <= 1'b1;
        for (i = 0; i < 9; i++) begin
            pulse(i);
            rdchk(hyb_a, 32'h0);
            move(16'sh14, 16'sh0, 1);
        end
        for (i = 0; i < 3; i++) begin
            full_closed_mode <= (i != 0);
            servo_on <= (i != 1);
            drive_is_standard <= (i == 2);
            move(16'sh1f4, 16'sh0, 1);
            rdchk(hyb_a, 32'h0);
        end
        drive_is_standard <= 1'b0;
        apb(`FCHD_ADDR_EXCESS_THR, 1'b1, 32'h8000000);
        apb(`FCHD_ADDR_CLEAR_INT, 1'b1, 32'h1);
        apb(st_a, 1'b1, 32'h7);
        servo_on <= 1'b1;
        full_closed_mode <= 1'b1;
        move(16'sh4000, 16'sh3fff, 8200);
        rdchk(hyb_a, 32'h8);
        rdchk(st_a, 32'h2);
        servo_on <= 1'b0;
        move(16'sh0, 16'sh4000, 14000);
        servo_on <= 1'b1;
        move(16'sh0, 16'sh1, 8200);
        rdchk(hyb_a, 32'hffffdff8);
        rdchk(`FCHD_ADDR_VELOCITY, 32'h0);
        apb(`FCHD_ADDR_CLEAR_INT, 1'b1, 32'h0);
        move(16'sh4000, 16'sh3fff, 8200);
        rdchk(hyb_a, 32'h0);
        stop_test();
    end

    // the tests take about 39k cycles
    initial begin
        #5000000;
        fail_count++;
        stop_test();
    end
endmodule
